// File: hw/vectored_interrupt_controller.sv
// Function
// - watchdog NMI ignores enable and masks, beats all, vector 0004H
// - NMI or any unmasked pending request raises standby release
// - eight maskable sources: one pin, seven internal, each masked
// - simultaneous maskable requests served priority 0 first, 7 last
// - pin edge priority 1 vector 0006H; A/D priority 2 vector 0008H
// - watch timer priority 3 0x000a; timer A priority 4 0x000c
// - timer B priority 5 0x000e; key return priority 6 0x0010
// - watch interval lowest priority 7, vector 0012H
// - overflow gives NMI in mode 1, priority-0 request in interval mode
// - flags set by event or write 1, cleared by ack, reset, write 0
// - acknowledged source flag cleared before its routine starts
// - flag register at FFE0H, reset 00H, fixed bit order
// - mask register at FFE4H, same order, resets to FFH
// - mask 0 allows service, mask 1 blocks but flag still records
// - watchdog flag accessible only in interval mode; else keep cleared
// - watchdog mask bit reads undefined in watchdog modes
// - pin edges counted even when pin is an output; mask first
// - maskable ack needs flag 1, mask 0 and global enable 1
// - on ack core saves status and PC, then global enable cleared
// - edge select 00 falling, 01 rising, 11 both, 10 prohibited
// - pending request stays until it can be acknowledged
`include "vic_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module vectored_interrupt_controller
  import vic_pkg::*;
#(
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned DATA_W = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  // interrupt sources
  input  wire logic              wdtOverflow,
  input  wire wdt_mode_e         wdtMode,
  input  wire logic              sharedIrqPin,
  input  wire logic              adcDone,
  input  wire logic              watchTimerEvt,
  input  wire logic              timerAMatch,
  input  wire logic              timerBMatch,
  input  wire logic              keyReturnEvt,
  input  wire logic              watchIntervalEvt,
  // core handshake
  input  wire logic              globalIrqEnable,
  input  wire logic              irqTaken,
  output logic                   irqOffer,
  output logic      [15:0]       irqVector,
  output logic                   irqIsNmi,
  output logic                   ieClear,
  output logic                   standbyRelease
);

  // ==========================================================
  // state
  logic [7:0]         flags_q;
  logic [7:0]         flags_d;
  logic [7:0]         mask_q;
  logic [1:0]         edgeSel_q;
  logic               nmiPend_q;
  logic               pinSync1_q;
  logic               pinSync2_q;
  logic               pinLast_q;
  logic [1:0]         pinFill_q;
  offer_state_e       state_q;
  logic               offer_q;
  logic [15:0]        vector_q;
  logic               isNmi_q;
  logic [2:0]         srcIdx_q;
  logic               ieClear_q;
  logic               standby_q;
  logic [DATA_W-1:0]  rdata_q;

  logic               intervalMode;
  logic               pinRise;
  logic               pinFall;
  logic               pinEdge;
  logic [7:0]         srcEvent;
  logic [7:0]         ackClr;
  logic [7:0]         wrOk;
  logic               wrFlags;
  logic [7:0]         eligible;
  logic               winAny;
  logic [2:0]         winIdx;
  logic               accept;

  assign intervalMode = (wdtMode == WDT_INTERVAL);
  assign accept       = (state_q == OFFER_WAIT) && irqTaken;
  assign wrFlags      = regWr && (regAddr == `VIC_FLAG_ADDR);

  // ==========================================================
  // shared pin synchroniser and edge detect
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinSync1_q <= 1'b0;
      pinSync2_q <= 1'b0;
      pinLast_q  <= 1'b0;
    end else begin
      pinSync1_q <= sharedIrqPin;
      pinSync2_q <= pinSync1_q;
      pinLast_q  <= pinSync2_q;
    end
  end

  // no false edge from the reset values of the pin flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinFill_q <= 2'h0;
    end else if (pinFill_q != 2'h3) begin
      pinFill_q <= pinFill_q + 2'h1;
    end
  end

  assign pinRise = (pinFill_q == 2'h3) && pinSync2_q && !pinLast_q;
  assign pinFall = (pinFill_q == 2'h3) && !pinSync2_q && pinLast_q;

  // pin level seen whatever its port direction
  always_comb begin
    case (edge_sel_e'(edgeSel_q))
      EDGE_FALL: pinEdge = pinFall;
      EDGE_RISE: pinEdge = pinRise;
      EDGE_BOTH: pinEdge = pinRise || pinFall;
      default:   pinEdge = 1'b0;
    endcase
  end

  // ==========================================================
  // source events in flag bit order
  assign srcEvent = {watchIntervalEvt, keyReturnEvt, timerBMatch,
                     timerAMatch, watchTimerEvt, adcDone, pinEdge,
                     wdtOverflow && intervalMode};

  // watchdog flag only touched by software in interval mode
  assign wrOk = {7'h7f, intervalMode};

  always_comb begin
    ackClr = 8'h00;
    if (accept && !isNmi_q) begin
      ackClr[srcIdx_q] = 1'b1;
    end
  end

  // ==========================================================
  // request flags, set beats clear
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      always_comb begin
        if (srcEvent[gi] || (wrFlags && wrOk[gi] && regWdata[gi])) begin
          flags_d[gi] = 1'b1;
        end else if (ackClr[gi] ||
                     (wrFlags && wrOk[gi] && !regWdata[gi])) begin
          flags_d[gi] = 1'b0;
        end else begin
          flags_d[gi] = flags_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= `VIC_FLAG_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ==========================================================
  // mask and edge select registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask_q <= `VIC_MASK_RST;
    end else if (regWr && regAddr == `VIC_MASK_ADDR) begin
      mask_q <= regWdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edgeSel_q <= `VIC_EDGE_RST;
    end else if (regWr && regAddr == `VIC_EDGE_ADDR) begin
      edgeSel_q <= regWdata[`VIC_EDGE_MSB:`VIC_EDGE_LSB];
    end
  end

  // ==========================================================
  // non-maskable watchdog request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nmiPend_q <= 1'b0;
    end else if (wdtOverflow && wdtMode == WDT_MODE1) begin
      nmiPend_q <= 1'b1;
    end else if (accept && isNmi_q) begin
      nmiPend_q <= 1'b0;
    end
  end

  // ==========================================================
  // fixed priority, bit 0 highest
  assign eligible = flags_q & ~mask_q;

  always_comb begin
    winAny = |eligible;
    winIdx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (eligible[i]) begin
        winIdx = 3'(i);
      end
    end
  end

  // ==========================================================
  // offer to the core
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= OFFER_IDLE;
      offer_q  <= 1'b0;
      vector_q <= 16'h0000;
      isNmi_q  <= 1'b0;
      srcIdx_q <= 3'h0;
    end else begin
      case (state_q)
        OFFER_IDLE: begin
          if (nmiPend_q) begin
            state_q  <= OFFER_WAIT;
            offer_q  <= 1'b1;
            vector_q <= `VIC_VEC_NMI;
            isNmi_q  <= 1'b1;
          end else if (globalIrqEnable && winAny && !ieClear_q) begin
            // core enable not yet dropped while the clear pulse stands
            state_q  <= OFFER_WAIT;
            offer_q  <= 1'b1;
            // 0004H plus two per priority step
            vector_q <= `VIC_VEC_BASE
              + {12'h000, winIdx, 1'b0};
            isNmi_q  <= 1'b0;
            srcIdx_q <= winIdx;
          end
        end
        OFFER_WAIT: begin
          if (irqTaken) begin
            state_q <= OFFER_IDLE;
            offer_q <= 1'b0;
          end
        end
        default: begin
          state_q <= OFFER_IDLE;
          offer_q <= 1'b0;
        end
      endcase
    end
  end

  // global enable dropped by the core after it stacks status and PC
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ieClear_q <= 1'b0;
    end else begin
      ieClear_q <= accept;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      standby_q <= 1'b0;
    end else begin
      standby_q <= nmiPend_q || winAny;
    end
  end

  // ==========================================================
  // read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (regRd) begin
      if (regAddr == `VIC_FLAG_ADDR) begin
        rdata_q <= {flags_q[7:1], flags_q[0] && intervalMode};
      end else if (regAddr == `VIC_MASK_ADDR) begin
        // watchdog mask bit not meaningful outside interval mode
        rdata_q <= {mask_q[7:1], mask_q[0] && intervalMode};
      end else if (regAddr == `VIC_EDGE_ADDR) begin
        rdata_q <= {4'h0, edgeSel_q, 2'h0};
      end else begin
        rdata_q <= '0;
      end
    end else begin
      rdata_q <= '0;
    end
  end

  assign regRdata       = rdata_q;
  assign irqOffer       = offer_q;
  assign irqVector      = vector_q;
  assign irqIsNmi       = isNmi_q;
  assign ieClear        = ieClear_q;
  assign standbyRelease = standby_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_idle_nmi;
    state_q == OFFER_IDLE && nmiPend_q;
  endsequence

  sequence s_idle_maskable;
    state_q == OFFER_IDLE && !nmiPend_q && globalIrqEnable && winAny &&
      !ieClear_q;
  endsequence

  sequence s_accept_maskable;
    accept && !isNmi_q;
  endsequence

  a_nmi_vector: assert property (s_idle_nmi |=>
      offer_q && isNmi_q && vector_q == 16'h0004)
    else $error("nmi offer missing or wrong vector");

  a_standby_follow: assert property (
      (nmiPend_q || winAny) |=> standby_q)
    else $error("standby release not raised");

  a_prio_vector: assert property (s_idle_maskable |=>
      offer_q && !isNmi_q &&
      vector_q == 16'h0004 + {12'h000, $past(winIdx), 1'b0})
    else $error("maskable vector does not match winner");

  a_prio_order: assert property (s_idle_maskable |->
      (eligible & ((8'h01 << winIdx) - 8'h01)) == 8'h00)
    else $error("lower priority chosen over higher");

  a_ie_gate: assert property (
      (state_q == OFFER_IDLE && !nmiPend_q && !globalIrqEnable)
      |=> !offer_q)
    else $error("offer made while global enable low");

  a_offer_hold: assert property ((offer_q && !irqTaken) |=>
      offer_q && $stable(vector_q) && $stable(isNmi_q))
    else $error("offer dropped before core accepted");

  a_ack_clear: assert property (
      (s_accept_maskable ##0 !srcEvent[srcIdx_q])
      |=> !flags_q[$past(srcIdx_q)] ##1 ieClear_q == 1'b0)
    else $error("serviced flag not cleared");

  a_ie_clear: assert property (accept |=>
      ieClear_q ##1 (!ieClear_q || accept))
    else $error("global enable clear pulse missing");

  a_ie_settle: assert property (ieClear_q |=>
      !offer_q || isNmi_q)
    else $error("maskable offer before global enable dropped");

  a_wdt_route: assert property (
      (wdtOverflow && wdtMode == WDT_MODE1)
      |=> nmiPend_q && !(flags_q[0] && !$past(flags_q[0])))
    else $error("mode 1 overflow routed wrongly");

  a_wdt_interval: assert property (
      (wdtOverflow && intervalMode)
      |=> flags_q[0] && $stable(nmiPend_q))
    else $error("interval overflow routed wrongly");

  a_wdt_readback: assert property (
      (regRd && regAddr == `VIC_FLAG_ADDR && !intervalMode)
      |=> !regRdata[0])
    else $error("watchdog flag visible outside interval mode");

  a_pin_rise: assert property (
      (edgeSel_q == 2'h1 && pinRise) |=> flags_q[1])
    else $error("rising pin edge lost");

  a_mask_block: assert property (
      (state_q == OFFER_IDLE && !nmiPend_q &&
       (flags_q & ~mask_q) == 8'h00) |=> !offer_q)
    else $error("masked request offered");

endmodule

`default_nettype wire

// File: hw/vic_cfg.svh
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH

// ==========================================================
// register map
`define VIC_FLAG_ADDR 16'hffe0
`define VIC_MASK_ADDR 16'hffe4
`define VIC_EDGE_ADDR 16'hffec

// ==========================================================
// reset values
`define VIC_FLAG_RST 8'h00
`define VIC_MASK_RST 8'hff
`define VIC_EDGE_RST 2'h0

// ==========================================================
// field positions
`define VIC_EDGE_LSB 2
`define VIC_EDGE_MSB 3
`define VIC_WDT_BIT 0
`define VIC_PIN_BIT 1

// ==========================================================
// vector table
`define VIC_VEC_NMI 16'h0004
`define VIC_VEC_BASE 16'h0004

`endif

// File: hw/vic_pkg.sv
package vic_pkg;

  // watchdog operating mode, driven by the watchdog block
  typedef enum logic [1:0] {
    WDT_INTERVAL = 2'h0,
    WDT_MODE1    = 2'h1,
    WDT_MODE2    = 2'h2
  } wdt_mode_e;

  // valid edge for the shared interrupt pin
  typedef enum logic [1:0] {
    EDGE_FALL = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_NONE = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_sel_e;

  // offer handshake toward the core
  typedef enum logic {
    OFFER_IDLE,
    OFFER_WAIT
  } offer_state_e;

endpackage

// File: tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// core sequencer model
module core_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // bench control
  input  wire logic       enableReq,
  input  wire logic [3:0] takeDelay,
  // handshake
  input  wire logic       irqOffer,
  input  wire logic       ieClear,
  output logic            irqTaken,
  output logic            globalIrqEnable
);
  logic [3:0] waitQ;
  logic       ieQ;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitQ <= 4'h0;
      ieQ   <= 1'b0;
    end else begin
      waitQ <= (irqOffer && !irqTaken) ? waitQ + 4'h1 : 4'h0;
      ieQ   <= ieClear ? 1'b0 : enableReq;
    end
  end

  // accept after a bench-chosen stall
  assign irqTaken        = irqOffer && (waitQ >= takeDelay);
  assign globalIrqEnable = ieQ;
endmodule
`default_nettype wire

// File: tb/testbench.sv
`include "vic_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vic_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [15:0] regAddr = 16'h0;
  logic [7:0]  regWdata = 8'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [7:0]  regRdata;
  logic [6:0]  evt = 7'h0;
  wdt_mode_e   wdtMode = WDT_INTERVAL;
  logic        sharedIrqPin = 1'b1;
  logic        enableReq = 1'b0;
  logic [3:0]  takeDelay = 4'h0;
  logic        irqTaken, irqOffer, irqIsNmi, ieClear;
  logic        standbyRelease, globalIrqEnable;
  logic [15:0] irqVector;
  logic [16:0] vecQ[$];
  logic [7:0]  rdQ[$];
  logic        rdPend = 1'b0;
  logic        tkPend = 1'b0;
  logic [31:0] rs = 32'd2210;
  int          nErrors = 0;
  int          compares = 0;

  vectored_interrupt_controller vectored_interrupt_controller_i (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .wdtOverflow(evt[0]), .wdtMode(wdtMode), .sharedIrqPin(sharedIrqPin),
    .adcDone(evt[1]), .watchTimerEvt(evt[2]), .timerAMatch(evt[3]),
    .timerBMatch(evt[4]), .keyReturnEvt(evt[5]),
    .watchIntervalEvt(evt[6]), .globalIrqEnable(globalIrqEnable),
    .irqTaken(irqTaken), .irqOffer(irqOffer), .irqVector(irqVector),
    .irqIsNmi(irqIsNmi), .ieClear(ieClear),
    .standbyRelease(standbyRelease));

  core_model core_model_i (
    .clk(clk), .resetn(resetn), .enableReq(enableReq),
    .takeDelay(takeDelay), .irqOffer(irqOffer), .ieClear(ieClear),
    .irqTaken(irqTaken), .globalIrqEnable(globalIrqEnable));

  // ======
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input string w, input logic [16:0] e,
                     input logic [16:0] g);
    compares++;
    if (g !== e) begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic stop_test();
    if (nErrors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    rdQ.push_back(e);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic ev(input logic [6:0] e);
    rs = xs(rs);
    takeDelay <= rs[3:0];
    evt       <= e;
    @(posedge clk);
    evt <= 7'h0;
    @(posedge clk);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (vecQ.size() != 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("offers left", 17'h0, 17'(vecQ.size()));
    repeat (4) @(posedge clk);
  endtask

  // ======
  // clock, watchdog, monitor
  initial begin
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    nErrors++;
    stop_test();
  end

  always @(posedge clk) begin
    if (rdPend) chk("read data", {9'h0, rdQ.pop_front()}, {9'h0, regRdata});
    rdPend <= regRd;
    if (tkPend) chk("ie clear", 17'h1, {16'h0, ieClear});
    tkPend <= (irqOffer === 1'b1 && irqTaken === 1'b1);
    if (irqOffer === 1'b1 && irqTaken === 1'b1) begin
      if (vecQ.size() == 0) chk("spare offer", 17'h0, {irqIsNmi, irqVector});
      else chk("vector", vecQ.pop_front(), {irqIsNmi, irqVector});
    end
  end

  // ======
  // scenarios
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(`VIC_FLAG_ADDR, 8'h00);
    rd(`VIC_MASK_ADDR, 8'hff);
    rd(`VIC_EDGE_ADDR, 8'h00);
    rd(16'hffe2, 8'h00);
    // all sources but the pin at once, core disabled
    wr(`VIC_MASK_ADDR, 8'h00);
    ev(7'h7f);
    rd(`VIC_FLAG_ADDR, 8'hfd);
    chk("standby", 17'h1, {16'h0, standbyRelease});
    for (int i = 0; i < 8; i++) begin
      if (i != 1) vecQ.push_back({1'b0, 16'h0004 + 16'(2 * i)});
    end
    enableReq <= 1'b1;
    drain();
    rd(`VIC_FLAG_ADDR, 8'h00);
    // masked source held then released
    wr(`VIC_MASK_ADDR, 8'hff);
    ev(7'h02);
    rd(`VIC_FLAG_ADDR, 8'h04);
    chk("standby", 17'h0, {16'h0, standbyRelease});
    vecQ.push_back({1'b0, 16'h0008});
    wr(`VIC_MASK_ADDR, 8'hfb);
    drain();
    // software set and clear
    wr(`VIC_MASK_ADDR, 8'h7f);
    vecQ.push_back({1'b0, 16'h0012});
    wr(`VIC_FLAG_ADDR, 8'h80);
    drain();
    wr(`VIC_MASK_ADDR, 8'hff);
    wr(`VIC_FLAG_ADDR, 8'h10);
    rd(`VIC_FLAG_ADDR, 8'h10);
    wr(`VIC_FLAG_ADDR, 8'h00);
    rd(`VIC_FLAG_ADDR, 8'h00);
    // watchdog mode 1, core disabled, all masked but adc
    enableReq <= 1'b0;
    wdtMode   <= WDT_MODE1;
    wr(`VIC_MASK_ADDR, 8'hfb);
    vecQ.push_back({1'b1, `VIC_VEC_NMI});
    ev(7'h03);
    drain();
    rd(`VIC_FLAG_ADDR, 8'h04);
    vecQ.push_back({1'b0, 16'h0008});
    enableReq <= 1'b1;
    drain();
    // mode 2 overflow raises neither request
    wdtMode <= WDT_MODE2;
    wr(`VIC_MASK_ADDR, 8'hff);
    ev(7'h01);
    rd(`VIC_FLAG_ADDR, 8'h00);
    chk("standby", 17'h0, {16'h0, standbyRelease});
    wdtMode <= WDT_INTERVAL;
    // edge select codes on the shared pin
    wr(`VIC_MASK_ADDR, 8'hff);
    for (int c = 0; c < 4; c++) begin
      wr(`VIC_EDGE_ADDR, 8'(c << 2));
      wr(`VIC_FLAG_ADDR, 8'h00);
      sharedIrqPin <= 1'b0;
      repeat (8) @(posedge clk);
      rd(`VIC_FLAG_ADDR, (c == 0 || c == 3) ? 8'h02 : 8'h00);
      wr(`VIC_FLAG_ADDR, 8'h00);
      sharedIrqPin <= 1'b1;
      repeat (8) @(posedge clk);
      rd(`VIC_FLAG_ADDR, (c == 1 || c == 3) ? 8'h02 : 8'h00);
    end
    wr(`VIC_FLAG_ADDR, 8'h00);
    // random mask values read back
    repeat (6) begin
      rs = xs(rs);
      wr(`VIC_MASK_ADDR, rs[7:0]);
      rd(`VIC_MASK_ADDR, rs[7:0]);
    end
    wr(`VIC_MASK_ADDR, 8'hff);
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule
`default_nettype wire
